// ==== hdl/node_ctl_pkg.sv ====
// Purpose: Shared constants for the node-power / limp-home control pair
// Assumes: One 125 MHz core clock on each end
// Notes: SPI frame is 16 bits: write flag, 7-bit address, 8-bit data
package node_ctl_pkg;
  localparam int CLK_PERIOD_NS = 8; // Core clock period
  // Register byte addresses on the SPI
  localparam logic [6:0] ADDR_INH_LIMP_CONFIG = 7'h1a;
  localparam logic [6:0] ADDR_WAKE_CONFIG = 7'h1b;
  localparam logic [6:0] ADDR_SDO_IRQ_CONFIG = 7'h1e;
  localparam logic [6:0] ADDR_FAULT_FLAG_BASE = 7'h50;
  localparam logic [6:0] ADDR_FAULT_MASK_BASE = 7'h58;
  localparam int FAULT_REGS = 5; // Flag bytes 0x50..0x54
  // Field positions in the node-power / limp, wake and SDO interrupt configurations
  localparam int CFG_NODE_POWER_DIS = 6;
  localparam int CFG_LIMP_EN = 5;
  localparam int CFG_LIMP_SEL_HI = 3;
  localparam int CFG_LIMP_SEL_LO = 2;
  localparam int CFG_LIMP_CLEAR = 1;
  localparam int WAKE_BUS_DIS = 0;
  localparam int SDO_IRQ_EN = 0;
  // Values after reset
  localparam logic [7:0] RST_INH_LIMP_CONFIG = 8'h00;
  localparam logic [7:0] RST_WAKE_CONFIG = 8'h00;
  localparam logic [7:0] RST_SDO_IRQ_CONFIG = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'h00;
  // Error-free watchdog services needed to release limp, per selector
  localparam logic [3:0] LIMP_GOOD_SEL0 = 4'h1;
  localparam logic [3:0] LIMP_GOOD_SEL1 = 4'h2;
  localparam logic [3:0] LIMP_GOOD_SEL2 = 4'h4;
  localparam logic [3:0] LIMP_GOOD_SEL3 = 4'h8;
  // SPI framing
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] ALL_BITS = 5'h10;
  // Timing
  localparam int SCK_MAX_KHZ = 4000; // Fastest SPI clock allowed
  localparam int SCK_HALF_CYC =
    (500000 / SCK_MAX_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CS_WAIT_US = 10; // Least wait after select in sleep
  localparam int SLEEP_CS_WAIT_CYC =
    (SLEEP_CS_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_REC_NS = 355; // Least active recessive phase
  localparam int ACT_REC_CYC =
    (ACT_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== hdl/node_link_if.sv ====
// Purpose: Pin bundle between the transceiver control and its host
// Assumes: Testbench resolves three-state pins from the enables
// Notes: No clocking block; both ends sample with their own clock
`timescale 1ns/1ps
`default_nettype none
interface node_link_if;
  logic chip_select_n; // SPI select, active low
  logic sclk; // SPI clock from host
  logic sdi; // Host to device data
  logic sdo; // Device to host data or interrupt
  logic sdo_oe; // Device drives sdo
  logic fault_irq_n; // Dedicated interrupt, active low
  logic txd; // Transmit bit, high is recessive
  logic rxd; // Receive bit, high is recessive
  logic node_power; // Node-power pin level
  logic node_power_oe; // Node-power pin driven
  modport dev (input chip_select_n, sclk, sdi, txd,
               output sdo, sdo_oe, fault_irq_n, rxd, node_power,
               node_power_oe);
  modport host (output chip_select_n, sclk, sdi, txd,
                input sdo, sdo_oe, fault_irq_n, rxd, node_power,
                node_power_oe);
endinterface
`default_nettype wire

// ==== hdl/node_ctl_dev.sv ====
// Purpose: Device end: node-power/limp pin, faults, SPI slave, bus edge
// Assumes: Mode, watchdog and fail-safe logic drive the trigger inputs
// Notes: SPI mode 0, MSB first, pins synchronised before use
// Behaviour
// - Node power on in every non-sleep mode
// - Sleep turns node power off, high impedance
// - Config bit 6 disables node power
// - Config bit 5 makes pin limp indicator
// - Watchdog error limit turns limp on
// - Fail-safe entry turns limp on if enabled
// - Limp stays on until error-free count met
// - Writing config bit 1 turns limp off
// - Interrupt is OR of unmasked fault flags
// - SDO signals interrupt while select is high
// - Access only with select low and clocks
// - SDI sampled as host data while selected
// - Host keeps SPI clock at most 4 MHz
// - Host waits 10 us in sleep first
// - Wake config bit 0 ignores bus wake
// - Drive recessive actively briefly, then release
// - High is recessive, low dominant, dominant wins
// - Host disables SDO interrupt on shared bus
`timescale 1ns/1ps
`default_nettype none
module node_ctl_dev
  import node_ctl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  node_link_if.dev link,
  input wire logic SLEEP_MODE_IN,
  input wire logic WD_LIMIT_IN,
  input wire logic WD_GOOD_IN,
  input wire logic FAILSAFE_EN_IN,
  input wire logic FAILSAFE_ENTRY_IN,
  input wire logic [8*FAULT_REGS-1:0] FAULT_EVENT_IN,
  input wire logic BUS_WAKE_PATTERN_IN,
  input wire logic BUS_DOMINANT_IN,
  output logic BUS_WAKE_REQ_OUT,
  output logic DRV_DOMINANT_OUT,
  output logic DRV_ACTIVE_REC_OUT,
  output logic LIMP_ACTIVE_OUT
);
  logic [5:0] sync1; // First stage, read only by sync2
  logic [5:0] sync2; // Synchronised pins
  logic cs_n, sck, sdi_s, txd_s, wake_s, dom_s; // Named pin views
  logic sck_prev; // For clock edge detection
  logic txd_prev; // For transmit edge detection
  logic sck_rise, sck_fall; // One-cycle edge strobes
  logic [4:0] bit_cnt; // Bits received in this frame
  logic [14:0] in_shift; // Received header and data
  logic [14:0] next_in_shift; // Shift with the current bit
  logic [7:0] out_shift; // Read data being sent
  logic [7:0] inh_limp_config; // Node power and limp setup
  logic [7:0] wake_config; // Bus wake control
  logic [7:0] sdo_irq_config; // Interrupt on SDO control
  logic [7:0] fault_flag [FAULT_REGS]; // Sticky fault flags
  logic [7:0] fault_mask [FAULT_REGS]; // One masks the flag bit
  logic wr_strobe; // Completed write frame
  logic [6:0] wr_addr; // Its address
  logic [7:0] wr_data; // Its data
  logic limp_active; // Limp indicator state
  logic limp_clear; // Software release pulse
  logic [3:0] good_cnt; // Error-free services seen
  logic [7:0] act_cnt; // Active recessive cycles left
  logic any_fault; // Unmasked fault present

  // Read decode used for SPI read data
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == ADDR_INH_LIMP_CONFIG) begin
      r = inh_limp_config;
    end else if (a == ADDR_WAKE_CONFIG) begin
      r = wake_config;
    end else if (a == ADDR_SDO_IRQ_CONFIG) begin
      r = sdo_irq_config;
    end
    for (int i = 0; i < FAULT_REGS; i++) begin
      if (a == ADDR_FAULT_FLAG_BASE + 7'(i)) begin
        r = fault_flag[i];
      end
      if (a == ADDR_FAULT_MASK_BASE + 7'(i)) begin
        r = fault_mask[i];
      end
    end
    return r;
  endfunction

  // Needed error-free count for a selector value
  function automatic logic [3:0] good_need(input logic [1:0] sel);
    logic [3:0] n;
    unique case (sel)
      2'h0: n = LIMP_GOOD_SEL0;
      2'h1: n = LIMP_GOOD_SEL1;
      2'h2: n = LIMP_GOOD_SEL2;
      2'h3: n = LIMP_GOOD_SEL3;
    endcase
    return n;
  endfunction

  // Two flops on every pin input; host clock is not assumed related
  // Reset to each pin's idle level so no false edge follows reset
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1 <= 6'h09;
      sync2 <= 6'h09;
    end else begin
      sync1 <= {BUS_DOMINANT_IN, BUS_WAKE_PATTERN_IN, link.txd,
                link.sdi, link.sclk, link.chip_select_n};
      sync2 <= sync1;
    end
  end
  assign cs_n = sync2[0];
  assign sck = sync2[1];
  assign sdi_s = sync2[2];
  assign txd_s = sync2[3];
  assign wake_s = sync2[4];
  assign dom_s = sync2[5];
  assign sck_rise = sck & ~sck_prev & ~cs_n;
  assign sck_fall = ~sck & sck_prev & ~cs_n;
  assign next_in_shift = {in_shift[13:0], sdi_s};

  // Edge history
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sck_prev <= 1'b0;
      txd_prev <= 1'b1;
    end else begin
      sck_prev <= sck;
      txd_prev <= txd_s;
    end
  end

  // SPI shift engine; select high aborts any partial frame
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bit_cnt <= 5'h00;
      in_shift <= 15'h0000;
      out_shift <= 8'h00;
      wr_strobe <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (cs_n) begin
        bit_cnt <= 5'h00;
      end else if (sck_rise && bit_cnt != ALL_BITS) begin
        in_shift <= next_in_shift;
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == HDR_BITS - 5'h01) begin
          out_shift <= read_reg(next_in_shift[6:0]);
        end
        // Write flag came in first and now sits at the top of the shift
        if (bit_cnt == ALL_BITS - 5'h01 && in_shift[14]) begin
          wr_strobe <= 1'b1;
          wr_addr <= next_in_shift[14:8];
          wr_data <= next_in_shift[7:0];
        end
      end else if (sck_fall && bit_cnt > HDR_BITS) begin
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  // Configuration registers; limp clear bit never stored
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      inh_limp_config <= RST_INH_LIMP_CONFIG;
      wake_config <= RST_WAKE_CONFIG;
      sdo_irq_config <= RST_SDO_IRQ_CONFIG;
      limp_clear <= 1'b0;
    end else begin
      limp_clear <= 1'b0;
      if (wr_strobe && wr_addr == ADDR_INH_LIMP_CONFIG) begin
        inh_limp_config <= wr_data & ~(8'h01 << CFG_LIMP_CLEAR);
        limp_clear <= wr_data[CFG_LIMP_CLEAR];
      end
      if (wr_strobe && wr_addr == ADDR_WAKE_CONFIG) begin
        wake_config <= wr_data;
      end
      if (wr_strobe && wr_addr == ADDR_SDO_IRQ_CONFIG) begin
        sdo_irq_config <= wr_data;
      end
    end
  end

  // Fault flags: write one clears, a new event in that cycle wins
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < FAULT_REGS; i++) begin
        fault_flag[i] <= 8'h00;
        fault_mask[i] <= RST_FAULT_MASK;
      end
    end else begin
      for (int i = 0; i < FAULT_REGS; i++) begin
        if (wr_strobe && wr_addr == ADDR_FAULT_FLAG_BASE + 7'(i)) begin
          fault_flag[i] <= (fault_flag[i] & ~wr_data)
                           | FAULT_EVENT_IN[8*i +: 8];
        end else begin
          fault_flag[i] <= fault_flag[i] | FAULT_EVENT_IN[8*i +: 8];
        end
        if (wr_strobe && wr_addr == ADDR_FAULT_MASK_BASE + 7'(i)) begin
          fault_mask[i] <= wr_data;
        end
      end
    end
  end

  // Combine every unmasked flag
  always_comb begin
    any_fault = 1'b0;
    for (int i = 0; i < FAULT_REGS; i++) begin
      any_fault = any_fault | (|(fault_flag[i] & ~fault_mask[i]));
    end
  end

  // Limp state; a trigger beats a release in the same cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      limp_active <= 1'b0;
      good_cnt <= 4'h0;
    end else begin
      if (inh_limp_config[CFG_LIMP_EN] &&
          (WD_LIMIT_IN || (FAILSAFE_EN_IN && FAILSAFE_ENTRY_IN))) begin
        limp_active <= 1'b1;
        good_cnt <= 4'h0;
      end else if (limp_clear) begin
        limp_active <= 1'b0;
        good_cnt <= 4'h0;
      end else if (limp_active && WD_GOOD_IN) begin
        if (good_cnt + 4'h1 >= good_need(
            inh_limp_config[CFG_LIMP_SEL_HI:CFG_LIMP_SEL_LO])) begin
          limp_active <= 1'b0;
          good_cnt <= 4'h0;
        end else begin
          good_cnt <= good_cnt + 4'h1;
        end
      end
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      link.node_power <= 1'b0;
      link.node_power_oe <= 1'b0;
      link.fault_irq_n <= 1'b1;
      link.sdo <= 1'b0;
      link.sdo_oe <= 1'b0;
      LIMP_ACTIVE_OUT <= 1'b0;
    end else begin
      link.node_power <= 1'b1;
      if (inh_limp_config[CFG_NODE_POWER_DIS]) begin
        link.node_power_oe <= 1'b0;
      end else if (inh_limp_config[CFG_LIMP_EN]) begin
        link.node_power_oe <= limp_active;
      end else begin
        link.node_power_oe <= ~SLEEP_MODE_IN;
      end
      link.fault_irq_n <= ~any_fault;
      LIMP_ACTIVE_OUT <= limp_active;
      if (!cs_n) begin
        // Data bits only after the header; zeros before
        link.sdo_oe <= 1'b1;
        link.sdo <= (bit_cnt >= HDR_BITS) ? out_shift[7] : 1'b0;
      end else begin
        link.sdo_oe <= sdo_irq_config[SDO_IRQ_EN];
        link.sdo <= ~any_fault;
      end
    end
  end

  // Bus side: polarity, wake gate and active recessive phase
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      link.rxd <= 1'b1;
      DRV_DOMINANT_OUT <= 1'b0;
      DRV_ACTIVE_REC_OUT <= 1'b0;
      BUS_WAKE_REQ_OUT <= 1'b0;
      act_cnt <= 8'h00;
    end else begin
      link.rxd <= ~dom_s;
      DRV_DOMINANT_OUT <= ~txd_s;
      BUS_WAKE_REQ_OUT <= wake_s & SLEEP_MODE_IN
                          & ~wake_config[WAKE_BUS_DIS];
      if (txd_s && !txd_prev) begin
        act_cnt <= 8'(ACT_REC_CYC);
      end else if (!txd_s) begin
        act_cnt <= 8'h00;
      end else if (act_cnt != 8'h00) begin
        act_cnt <= act_cnt - 8'h01;
      end
      DRV_ACTIVE_REC_OUT <= (txd_s && !txd_prev) ||
                            (txd_s && act_cnt > 8'h01);
    end
  end
endmodule // node_ctl_dev
`default_nettype wire

// ==== hdl/node_ctl_host.sv ====
// Purpose: Host end: SPI master for the transceiver control registers
// Assumes: One request at a time, held until DONE_OUT
// Notes: SPI mode 0 at about 3.7 MHz; device pins are synchronised
`timescale 1ns/1ps
`default_nettype none
module node_ctl_host
  import node_ctl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  node_link_if.host link,
  input wire logic REQ_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [6:0] REQ_ADDR_IN,
  input wire logic [7:0] REQ_DATA_IN,
  input wire logic SLEEP_IN,
  input wire logic TX_BIT_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [7:0] RD_DATA_OUT,
  output logic IRQ_OUT,
  output logic RX_BIT_OUT
);
  typedef enum {ST_IDLE, ST_WAIT, ST_LOW, ST_HIGH, ST_END} host_st_t;
  host_st_t state; // Transfer sequencer
  logic [3:0] sync1; // First stage, read only by sync2
  logic [3:0] sync2; // Synchronised device pins
  logic [10:0] tmr; // Phase timer
  logic [4:0] bits; // Bits clocked so far
  logic [15:0] tx_shift; // Outgoing frame
  logic [7:0] rx_shift; // Incoming read data
  logic [5:0] cs_hist; // Recent select levels, for the SDO interrupt view

  // Synchronise device outputs
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
    end else begin
      sync1 <= {link.rxd, link.sdo_oe, link.sdo, link.fault_irq_n};
      sync2 <= sync1;
    end
  end

  // Interrupt seen on its pin or on SDO between frames; bus bit out
  // SDO is trusted only once select has been high long enough for the
  // device to leave frame use and for its new level to pass the sync
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
      RX_BIT_OUT <= 1'b1;
      link.txd <= 1'b1;
      cs_hist <= 6'h3f;
    end else begin
      cs_hist <= {cs_hist[4:0], link.chip_select_n};
      IRQ_OUT <= ~sync2[0] | (link.chip_select_n & (&cs_hist)
                              & sync2[2] & ~sync2[1]);
      RX_BIT_OUT <= sync2[3];
      link.txd <= TX_BIT_IN;
    end
  end

  // Frame sequencer; half period keeps the clock at or under 4 MHz
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_IDLE;
      tmr <= 11'h000;
      bits <= 5'h00;
      tx_shift <= 16'h0000;
      rx_shift <= 8'h00;
      link.chip_select_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdi <= 1'b0;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      RD_DATA_OUT <= 8'h00;
    end else begin
      DONE_OUT <= 1'b0;
      if (tmr != 11'h000) begin
        tmr <= tmr - 11'h001;
      end
      unique case (state)
        ST_IDLE: begin
          if (REQ_IN) begin
            state <= ST_WAIT;
            BUSY_OUT <= 1'b1;
            link.chip_select_n <= 1'b0;
            tx_shift <= {REQ_WRITE_IN, REQ_ADDR_IN, REQ_DATA_IN};
            bits <= 5'h00;
            // Sleep needs the long wait before full-rate clocks
            tmr <= SLEEP_IN ? 11'(SLEEP_CS_WAIT_CYC)
                            : 11'(SCK_HALF_CYC);
          end
        end
        ST_WAIT: begin
          if (tmr == 11'h000) begin
            state <= ST_LOW;
            link.sdi <= tx_shift[15];
            tmr <= 11'(SCK_HALF_CYC);
          end
        end
        ST_LOW: begin
          if (tmr == 11'h000) begin
            state <= ST_HIGH;
            link.sclk <= 1'b1;
            rx_shift <= {rx_shift[6:0], sync2[1]};
            bits <= bits + 5'h01;
            tx_shift <= {tx_shift[14:0], 1'b0};
            tmr <= 11'(SCK_HALF_CYC);
          end
        end
        ST_HIGH: begin
          if (tmr == 11'h000) begin
            link.sclk <= 1'b0;
            link.sdi <= tx_shift[15];
            tmr <= 11'(SCK_HALF_CYC);
            state <= (bits == ALL_BITS) ? ST_END : ST_LOW;
          end
        end
        ST_END: begin
          if (tmr == 11'h000) begin
            state <= ST_IDLE;
            link.chip_select_n <= 1'b1;
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b1;
            RD_DATA_OUT <= rx_shift;
          end
        end
      endcase
    end
  end
endmodule // node_ctl_host
`default_nettype wire

// ==== dv/node_link_checker.sv ====
// Purpose: Pin checks between the host end and the device end
// Assumes: One core clock; reset asynchronous, active high
// Notes: Sees interface pins only, not the trigger inputs
`timescale 1ns/1ps
`default_nettype none
module node_link_checker
  import node_ctl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic fault_irq_n,
  input wire logic node_power,
  input wire logic node_power_oe
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [4:0] edges; // Clock rises in this frame
  logic [7:0] hi_len; // Length of the running high phase
  // Count clock rises per frame; a short frame shows at select rise
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) edges <= 5'h00;
    else if (chip_select_n) edges <= 5'h00;
    else if ($rose(sclk)) edges <= edges + 5'h01;
  end
  // Measure each high phase of the serial clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) hi_len <= 8'h00;
    else if (sclk) hi_len <= hi_len + 8'h01;
    else hi_len <= 8'h00;
  end
  // Select high long enough that the device, behind its pin sync,
  // has moved data out from frame data to the interrupt copy
  sequence s_quiet;
    (chip_select_n && sdo_oe && $stable(fault_irq_n)) [*5];
  endsequence
  sequence s_open;
    $fell(chip_select_n);
  endsequence
  a_sclk_when_selected: assert property (sclk |-> !chip_select_n)
    else $error("serial clock high while deselected");
  a_cs_setup_gap: assert property (s_open |-> !sclk [*8])
    else $error("clock too soon after select");
  a_frame_sixteen: assert property ($rose(chip_select_n) |-> edges == ALL_BITS)
    else $error("frame without sixteen clocks");
  a_sdi_held_high: assert property (sclk |-> $stable(sdi))
    else $error("data in moved while clock high");
  a_sclk_half_len: assert property
    ($fell(sclk) |-> hi_len >= 8'(SCK_HALF_CYC))
    else $error("serial clock high phase too short");
  a_power_high_drive: assert property (node_power_oe |-> node_power)
    else $error("node power driven low");
  a_sdo_irq_level: assert property (s_quiet |-> sdo == fault_irq_n)
    else $error("data out does not show interrupt");
  a_irq_clear_spi: assert property ($rose(fault_irq_n) |-> !chip_select_n)
    else $error("interrupt cleared outside access");
endmodule // node_link_checker
`default_nettype wire

// ==== dv/inh_limp_pin_control_test.sv ====
// Purpose: Self-checking bench of host end and device end together
// Assumes: 125 MHz clock, reset held 10 cycles
// Notes: Device trigger inputs are driven by hand; outputs read 1 ns late
`timescale 1ns/1ps
`default_nettype none
module inh_limp_pin_control_test import node_ctl_pkg::*;;
  logic clk = 1'b0; // Core clock
  logic rst = 1'b1; // Reset, active high
  logic req = 1'b0, req_wr = 1'b0; // Host request
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_data = 8'h00;
  logic sleep_spi = 1'b0, tx_bit = 1'b1, sleep_mode = 1'b0;
  logic wd_limit = 1'b0, wd_good = 1'b0, fs_en = 1'b0, fs_entry = 1'b0;
  logic [8*FAULT_REGS-1:0] fault_ev = '0; // Fault event pulses
  logic wake_pat = 1'b0, bus_dom = 1'b0;
  logic busy, done, irq, rx_bit, wake_req, drv_dom, drv_rec, limp;
  logic [7:0] rd_data, got; // Read data and last answer
  logic [3:0] need [4] = '{LIMP_GOOD_SEL0, LIMP_GOOD_SEL1, LIMP_GOOD_SEL2,
    LIMP_GOOD_SEL3}; // Good services to release limp
  int bad_count = 0, cmp_count = 0;
  node_link_if node_link_if_inst ();
  wire logic pwr = node_link_if_inst.node_power;
  wire logic pwr_oe = node_link_if_inst.node_power_oe;
  wire logic irq_n = node_link_if_inst.fault_irq_n;
  wire logic sdo = node_link_if_inst.sdo;
  wire logic sdo_oe = node_link_if_inst.sdo_oe;
  node_ctl_dev node_ctl_dev_inst (.CLK_IN(clk), .RST_IN(rst),
    .link(node_link_if_inst), .SLEEP_MODE_IN(sleep_mode),
    .WD_LIMIT_IN(wd_limit), .WD_GOOD_IN(wd_good), .FAILSAFE_EN_IN(fs_en),
    .FAILSAFE_ENTRY_IN(fs_entry), .FAULT_EVENT_IN(fault_ev),
    .BUS_WAKE_PATTERN_IN(wake_pat), .BUS_DOMINANT_IN(bus_dom),
    .BUS_WAKE_REQ_OUT(wake_req), .DRV_DOMINANT_OUT(drv_dom),
    .DRV_ACTIVE_REC_OUT(drv_rec), .LIMP_ACTIVE_OUT(limp));
  node_ctl_host node_ctl_host_inst (.CLK_IN(clk), .RST_IN(rst),
    .link(node_link_if_inst), .REQ_IN(req), .REQ_WRITE_IN(req_wr),
    .REQ_ADDR_IN(req_addr), .REQ_DATA_IN(req_data), .SLEEP_IN(sleep_spi),
    .TX_BIT_IN(tx_bit), .BUSY_OUT(busy), .DONE_OUT(done),
    .RD_DATA_OUT(rd_data), .IRQ_OUT(irq), .RX_BIT_OUT(rx_bit));
  node_link_checker node_link_checker_inst (.CLK_IN(clk), .RST_IN(rst),
    .chip_select_n(node_link_if_inst.chip_select_n),
    .sclk(node_link_if_inst.sclk), .sdi(node_link_if_inst.sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .fault_irq_n(irq_n),
    .node_power(pwr), .node_power_oe(pwr_oe));
  // Free-running core clock
  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // Single closing point for pass, fail and hang
  task end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Wait edges, then step past them so outputs have settled
  task clocks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One whole frame; request held until the done pulse is seen
  task xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_data <= d;
    for (i = 0; i < 3000; i++) begin
      clocks(1);
      if (i == 0) chk_bit(busy, 1'b1);
      if (done === 1'b1) break;
    end
    req <= 1'b0; // Dropped before the next edge, so no second frame
    got = rd_data;
    if (i == 3000) begin
      bad_count++;
      end_sim;
    end
    chk_bit(busy, 1'b0);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk_byte(got, e);
  endtask
  // Trigger pulse of one cycle: 0 limit, 1 good service, 2 fail-safe
  task pulse(input int which);
    @(posedge clk);
    case (which)
      0: wd_limit <= 1'b1;
      1: wd_good <= 1'b1;
      default: fs_entry <= 1'b1;
    endcase
    @(posedge clk);
    {wd_limit, wd_good, fs_entry} <= 3'h0;
  endtask
  task t_regs;
    chk_bit(pwr_oe, 1'b1);
    rd(ADDR_INH_LIMP_CONFIG, RST_INH_LIMP_CONFIG);
    rd(ADDR_WAKE_CONFIG, RST_WAKE_CONFIG);
    rd(ADDR_SDO_IRQ_CONFIG, RST_SDO_IRQ_CONFIG);
    rd(ADDR_FAULT_MASK_BASE, RST_FAULT_MASK);
    xfer(1'b1, 7'h30, 8'h5a);
    rd(7'h30, 8'h00);
  endtask
  task t_power;
    @(posedge clk);
    sleep_mode <= 1'b1;
    clocks(4);
    chk_bit(pwr_oe, 1'b0);
    sleep_mode <= 1'b0;
    clocks(4);
    chk_bit(pwr_oe, 1'b1);
    xfer(1'b1, ADDR_INH_LIMP_CONFIG, 8'h40);
    clocks(3);
    chk_bit(pwr_oe, 1'b0);
    rd(ADDR_INH_LIMP_CONFIG, 8'h40);
    xfer(1'b1, ADDR_INH_LIMP_CONFIG, 8'h00);
  endtask
  task t_limp;
    int s, k;
    fs_en <= 1'b1;
    for (s = 0; s < 4; s++) begin
      xfer(1'b1, ADDR_INH_LIMP_CONFIG, 8'h20 | 8'(s << 2));
      clocks(3);
      chk_bit(pwr_oe, 1'b0);
      pulse(2);
      clocks(3);
      chk_bit(limp, 1'b1);
      chk_bit(pwr_oe, 1'b1);
      for (k = 1; k < need[s]; k++) pulse(1);
      clocks(3);
      chk_bit(limp, 1'b1);
      pulse(1);
      clocks(3);
      chk_bit(limp, 1'b0);
    end
    fs_en <= 1'b0;
    pulse(2);
    clocks(3);
    chk_bit(limp, 1'b0);
    pulse(0);
    clocks(3);
    chk_bit(limp, 1'b1);
    xfer(1'b1, ADDR_INH_LIMP_CONFIG, 8'h2e);
    clocks(3);
    chk_bit(limp, 1'b0);
    rd(ADDR_INH_LIMP_CONFIG, 8'h2c);
    xfer(1'b1, ADDR_INH_LIMP_CONFIG, 8'h00);
  endtask
  task t_faults;
    int i;
    logic [7:0] b;
    for (i = 0; i < FAULT_REGS; i++) begin
      b = 8'h01 << i;
      @(posedge clk);
      fault_ev <= (8*FAULT_REGS)'(1) << (9 * i);
      @(posedge clk);
      fault_ev <= '0;
      clocks(3);
      chk_bit(irq_n, 1'b0);
      rd(ADDR_FAULT_FLAG_BASE + 7'(i), b);
      chk_bit(irq, 1'b1);
      xfer(1'b1, ADDR_FAULT_MASK_BASE + 7'(i), b);
      chk_bit(irq_n, 1'b1);
      xfer(1'b1, ADDR_FAULT_MASK_BASE + 7'(i), 8'h00);
      chk_bit(irq_n, 1'b0);
      xfer(1'b1, ADDR_FAULT_FLAG_BASE + 7'(i), b);
      rd(ADDR_FAULT_FLAG_BASE + 7'(i), 8'h00);
    end
    xfer(1'b1, ADDR_SDO_IRQ_CONFIG, 8'h01);
    clocks(3);
    chk_bit(sdo_oe, 1'b1);
    chk_bit(sdo, 1'b1);
    chk_bit(irq, 1'b0);
    pulse(3);
    @(posedge clk);
    fault_ev <= 40'h00000000ff;
    @(posedge clk);
    fault_ev <= '0;
    clocks(5);
    chk_bit(sdo, 1'b0);
    chk_bit(irq, 1'b1);
    xfer(1'b1, ADDR_FAULT_FLAG_BASE, 8'hff);
    xfer(1'b1, ADDR_SDO_IRQ_CONFIG, 8'h00);
    clocks(3);
    chk_bit(sdo_oe, 1'b0);
  endtask
  task t_wake;
    @(posedge clk);
    sleep_mode <= 1'b1;
    sleep_spi <= 1'b1;
    wake_pat <= 1'b1;
    clocks(5);
    chk_bit(wake_req, 1'b1);
    xfer(1'b1, ADDR_WAKE_CONFIG, 8'h01);
    clocks(3);
    chk_bit(wake_req, 1'b0);
    xfer(1'b1, ADDR_WAKE_CONFIG, 8'h00);
    sleep_mode <= 1'b0;
    sleep_spi <= 1'b0;
    wake_pat <= 1'b0;
  endtask
  task t_bus;
    int i, n;
    @(posedge clk);
    tx_bit <= 1'b0;
    bus_dom <= 1'b1;
    clocks(6);
    chk_bit(drv_dom, 1'b1);
    chk_bit(rx_bit, 1'b0);
    tx_bit <= 1'b1;
    bus_dom <= 1'b0;
    for (i = 0; i < 10 && drv_rec !== 1'b1; i++) clocks(1);
    for (n = 1; n < 200; n++) begin
      clocks(1);
      if (drv_rec !== 1'b1) break;
    end
    chk_byte(8'(n), 8'(ACT_REC_CYC));
    chk_bit(drv_dom, 1'b0);
    chk_bit(rx_bit, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    clocks(2);
    t_regs;
    t_power;
    t_limp;
    t_faults;
    t_wake;
    t_bus;
    end_sim;
  end
endmodule // inh_limp_pin_control_test
`default_nettype wire
